// ===== hw/calib_loop_lock_regs.sv
// Q calibration, shaping gain, phase detector, loop filter and lock detect registers
//
// Contract
// - Lower FIFO threshold in top byte, resets FF
// - Q scale bits 23:14, negated by bit 3
// - Q DC offset subtracted only when enabled
// - Round field selects mode, resets to 12-bit
// - Post-filter gain reads as 01 plus fraction
// - Post-filter shift bits 25:22, resets 1011
// - N count bits 21:8, resets all ones
// - Lag, frequency, lead gains four bits each
// - Lag, frequency, lead shifts five bits each
// - Accumulator held zero while bit 0 set
// - Bit 31 selects analog PLL lock status
// - VCO divider codes give 1x to 32x
// - Reference divider codes give /1 to /8
// - PLL clock select bit 24, enable 25
// - Below threshold adds selected increment
// - Above threshold subtracts half or quarter
`timescale 1ns/100ps
`default_nettype none
module calib_loop_lock_regs
  import calib_regs_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [4:0] cpu_addr,
  input wire logic [31:0] cpu_wdata,
  input wire logic cpu_wr_n,
  output logic [31:0] cpu_rdata,
  input wire logic analog_lock_pin,
  input wire logic digital_lock,
  output logic [7:0] fifo_lower_threshold,
  output logic [9:0] q_scale,
  output logic q_negate,
  output logic [9:0] q_offset,
  output logic q_subtract,
  output logic [1:0] q_round_mode,
  output logic [7:0] post_gain,
  output logic [3:0] post_shift,
  output logic [13:0] ped_n_count,
  output logic [7:0] ped_m_count,
  output logic invert_phase,
  output logic invert_freq,
  output logic disable_offset_freq,
  output logic [3:0] lag_gain,
  output logic [3:0] frq_gain,
  output logic [3:0] lead_gain,
  output logic [4:0] lag_shift,
  output logic [4:0] frq_shift,
  output logic [4:0] lead_shift,
  output logic zero_accum,
  output logic lock_indication,
  output logic [5:0] vco_multiplier,
  output logic [3:0] ref_divisor,
  output logic pll_enable,
  output logic pll_clock_select,
  output logic [20:0] phase_err_threshold,
  output logic [3:0] lock_inc_step,
  output logic [3:0] lock_dec_step
);
  logic [31:0] q_cal_reg;
  logic [31:0] gain_pe_reg;
  logic [31:0] loop_filt_reg;
  logic [31:0] lock_det_reg;
  logic wr_fall;
  logic analog_lock;
  logic wr_evt;
  logic [31:0] rdata_next;

  // Multiplier 2^code; unused codes 110 and 111 hold at 32x
  function automatic logic [5:0] vco_mult_of(input logic [2:0] code);
    logic [5:0] m;
    m = 6'h00;
    if (code > 3'h5) begin
      m = 6'h20;
    end else begin
      m[code] = 1'b1;
    end
    return m;
  endfunction : vco_mult_of

  // Divisor 2^code
  function automatic logic [3:0] ref_div_of(input logic [1:0] code);
    logic [3:0] d;
    d = 4'h0;
    d[code] = 1'b1;
    return d;
  endfunction : ref_div_of

  pin_sync wr_sync (
    .clk(clk),
    .srst(srst),
    .pin(cpu_wr_n),
    .reset_level(1'b1),
    .level(),
    .rise(),
    .fall(wr_fall)
  );

  pin_sync lock_sync (
    .clk(clk),
    .srst(srst),
    .pin(analog_lock_pin),
    .reset_level(1'b0),
    .level(analog_lock),
    .rise(),
    .fall()
  );

  // Address and data must be held stable across the write strobe;
  // they are sampled after the strobe has passed the synchroniser.
  assign wr_evt = wr_fall;

  always_ff @(posedge clk) begin
    if (srst) begin
      q_cal_reg <= Q_CAL_RESET;
    end else if (wr_evt && cpu_addr == Q_CAL_ADDR) begin
      q_cal_reg <= cpu_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      gain_pe_reg <= GAIN_PE_RESET;
    end else if (wr_evt && cpu_addr == GAIN_PE_ADDR) begin
      // M counts below four are stored as written; keeping them legal is up to software
      gain_pe_reg <= cpu_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      loop_filt_reg <= LOOP_FILT_RESET;
    end else if (wr_evt && cpu_addr == LOOP_FILT_ADDR) begin
      loop_filt_reg <= cpu_wdata & LOOP_FILT_WMASK;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      lock_det_reg <= LOCK_DET_RESET;
    end else if (wr_evt && cpu_addr == LOCK_DET_ADDR) begin
      lock_det_reg <= cpu_wdata;
    end
  end

  // Field views of the stored words
  assign fifo_lower_threshold = q_cal_reg[Q_THR_LSB +: 8];
  assign q_scale = q_cal_reg[Q_SCALE_LSB +: 10];
  assign q_negate = q_cal_reg[Q_NEG_BIT];
  assign q_offset = q_cal_reg[Q_OFFS_LSB +: 10];
  assign q_subtract = q_cal_reg[Q_SUB_BIT];
  assign q_round_mode = q_cal_reg[Q_RND_LSB +: 2];
  assign post_shift = gain_pe_reg[PS_SHIFT_LSB +: 4];
  assign ped_n_count = gain_pe_reg[N_CNT_LSB +: 14];
  assign ped_m_count = gain_pe_reg[M_CNT_LSB +: 8];
  assign invert_phase = loop_filt_reg[INV_PHASE_BIT];
  assign invert_freq = loop_filt_reg[INV_FREQ_BIT];
  assign disable_offset_freq = loop_filt_reg[DIS_OFFS_BIT];
  assign lag_gain = loop_filt_reg[LAG_GAIN_LSB +: 4];
  assign frq_gain = loop_filt_reg[FRQ_GAIN_LSB +: 4];
  assign lead_gain = loop_filt_reg[LEAD_GAIN_LSB +: 4];
  assign lag_shift = loop_filt_reg[LAG_SHIFT_LSB +: 5];
  assign frq_shift = loop_filt_reg[FRQ_SHIFT_LSB +: 5];
  assign lead_shift = loop_filt_reg[LEAD_SHIFT_LSB +: 5];
  assign zero_accum = loop_filt_reg[ZERO_ACC_BIT];
  assign pll_enable = lock_det_reg[PLL_EN_BIT];
  assign phase_err_threshold = lock_det_reg[PE_THR_LSB +: 21];

  // Gain carries its implied integer part 01 so the filter sees 1.0 to 1.984
  always_ff @(posedge clk) begin
    if (srst) begin
      post_gain <= {PS_GAIN_INT, GAIN_PE_RESET[PS_GAIN_LSB +: 6]};
    end else begin
      post_gain <= {PS_GAIN_INT, gain_pe_reg[PS_GAIN_LSB +: 6]};
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      lock_indication <= 1'b0;
    end else if (lock_det_reg[USE_ALOCK_BIT]) begin
      lock_indication <= analog_lock;
    end else begin
      lock_indication <= digital_lock;
    end
  end

  // A stopped PLL cannot clock the datapath, so the select also needs the enable
  always_ff @(posedge clk) begin
    if (srst) begin
      pll_clock_select <= 1'b0;
    end else begin
      pll_clock_select <= lock_det_reg[PLL_CLK_BIT] && lock_det_reg[PLL_EN_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      vco_multiplier <= 6'h01;
      ref_divisor <= 4'h1;
    end else begin
      vco_multiplier <= vco_mult_of(lock_det_reg[VCO_DIV_LSB +: 3]);
      ref_divisor <= ref_div_of(lock_det_reg[REF_DIV_LSB +: 2]);
    end
  end

  // Steps in sixteenths: increments 1, 2, 4, 8; decrement 8 or 4
  always_ff @(posedge clk) begin
    if (srst) begin
      lock_inc_step <= 4'h1;
      lock_dec_step <= DEC_STEP_HALF;
    end else begin
      lock_inc_step <= ref_div_of(lock_det_reg[INC_SEL_LSB +: 2]);
      lock_dec_step <= lock_det_reg[DEC_SEL_BIT] ? DEC_STEP_QUARTER : DEC_STEP_HALF;
    end
  end

  // Read mux; unmapped addresses read as zero
  always_comb begin
    rdata_next = 32'h00000000;
    unique case (cpu_addr)
      Q_CAL_ADDR: rdata_next = q_cal_reg;
      GAIN_PE_ADDR: rdata_next = gain_pe_reg;
      LOOP_FILT_ADDR: rdata_next = loop_filt_reg;
      LOCK_DET_ADDR: rdata_next = lock_det_reg;
      default: rdata_next = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cpu_rdata <= 32'h00000000;
    end else begin
      cpu_rdata <= rdata_next;
    end
  end

  q_thresh_a: assert property (@(posedge clk) disable iff (srst)
    (wr_evt && cpu_addr == Q_CAL_ADDR) |=> fifo_lower_threshold == $past(cpu_wdata[31:24]))
    else $error("lower threshold not written");

  q_scale_a: assert property (@(posedge clk) disable iff (srst)
    (wr_evt && cpu_addr == Q_CAL_ADDR) |=> {q_scale, q_negate} == {$past(cpu_wdata[23:14]), $past(cpu_wdata[3])})
    else $error("scale or negate mismatch");

  q_offset_a: assert property (@(posedge clk) disable iff (srst)
    (wr_evt && cpu_addr == Q_CAL_ADDR) |=> {q_offset, q_subtract} == {$past(cpu_wdata[13:4]), $past(cpu_wdata[2])})
    else $error("offset or subtract mismatch");

  q_round_a: assert property (@(posedge clk)
    srst |=> (q_round_mode == 2'h2 && ped_n_count == 14'h3FFF && ped_m_count == 8'hFF))
    else $error("round or counts reset wrong");

  post_gain_a: assert property (@(posedge clk) disable iff (srst)
    (wr_evt && cpu_addr == GAIN_PE_ADDR) |-> ##2 post_gain == {2'h1, $past(cpu_wdata[31:26], 2)})
    else $error("post gain wrong");

  post_shift_a: assert property (@(posedge clk)
    srst |=> post_shift == 4'hB)
    else $error("post shift reset wrong");

  n_count_a: assert property (@(posedge clk) disable iff (srst)
    (wr_evt && cpu_addr == GAIN_PE_ADDR) |=> ped_n_count == $past(cpu_wdata[21:8]))
    else $error("n count not written");

  loop_gain_a: assert property (@(posedge clk) disable iff (srst)
    (wr_evt && cpu_addr == LOOP_FILT_ADDR) |=> {lag_gain, frq_gain, lead_gain, lag_shift, frq_shift, lead_shift}
      == $past(cpu_wdata[27:1]))
    else $error("loop gains or shifts wrong");

  accum_zero_a: assert property (@(posedge clk) disable iff (srst)
    (wr_evt && cpu_addr == LOOP_FILT_ADDR && cpu_wdata[0]) |=> zero_accum [*2])
    else $error("accumulator clear not held");

  // The first edge after reset still shows the reset value, so only sampled-out-of-reset cycles count
  lock_sel_a: assert property (@(posedge clk) disable iff (srst)
    !$past(srst) |-> lock_indication == ($past(lock_det_reg[31]) ? $past(analog_lock) : $past(digital_lock)))
    else $error("lock source wrong");

  vco_mult_a: assert property (@(posedge clk) disable iff (srst)
    (wr_evt && cpu_addr == LOCK_DET_ADDR && cpu_wdata[30:28] == 3'h5) |-> ##2 vco_multiplier == 6'h20)
    else $error("vco multiplier wrong");

  pll_clk_a: assert property (@(posedge clk) disable iff (srst)
    pll_clock_select |-> $past(pll_enable))
    else $error("pll clock without enable");

  lock_step_a: assert property (@(posedge clk) disable iff (srst)
    !$past(srst) |-> lock_dec_step == ($past(lock_det_reg[0]) ? 4'h4 : 4'h8))
    else $error("decrement step wrong");

  reserved_a: assert property (@(posedge clk) disable iff (srst)
    (cpu_addr == LOOP_FILT_ADDR) |=> cpu_rdata[31] == 1'b0)
    else $error("reserved bit reads one");

  loop_shift_a: assert property (@(posedge clk) disable iff (srst)
    (wr_evt && cpu_addr == LOOP_FILT_ADDR) |=> {lag_shift, frq_shift, lead_shift} == $past(cpu_wdata[15:1]))
    else $error("loop shifts wrong");

  ref_div_a: assert property (@(posedge clk) disable iff (srst)
    !$past(srst) |-> ref_divisor == (4'h1 << $past(lock_det_reg[27:26])))
    else $error("reference divisor wrong");

  inc_step_a: assert property (@(posedge clk) disable iff (srst)
    !$past(srst) |-> lock_inc_step == (4'h1 << $past(lock_det_reg[2:1])))
    else $error("increment step wrong");

  pe_thresh_a: assert property (@(posedge clk) disable iff (srst)
    (wr_evt && cpu_addr == LOCK_DET_ADDR) |=> phase_err_threshold == $past(cpu_wdata[23:3]))
    else $error("phase error threshold not written");

  shift_write_a: assert property (@(posedge clk) disable iff (srst)
    (wr_evt && cpu_addr == GAIN_PE_ADDR) |=> post_shift == $past(cpu_wdata[25:22]))
    else $error("post shift not written");

  m_count_a: assert property (@(posedge clk) disable iff (srst)
    (wr_evt && cpu_addr == GAIN_PE_ADDR) |=> ped_m_count == $past(cpu_wdata[7:0]))
    else $error("m count not stored as written");

  round_write_a: assert property (@(posedge clk) disable iff (srst)
    (wr_evt && cpu_addr == Q_CAL_ADDR) |=> q_round_mode == $past(cpu_wdata[1:0]))
    else $error("round mode not written");

  pll_en_a: assert property (@(posedge clk) disable iff (srst)
    (wr_evt && cpu_addr == LOCK_DET_ADDR) |=> pll_enable == $past(cpu_wdata[25]))
    else $error("pll enable not written");

  pll_sel_on_a: assert property (@(posedge clk) disable iff (srst)
    (!$past(srst) && $past(lock_det_reg[24] && lock_det_reg[25])) |-> pll_clock_select)
    else $error("pll clock select not set");

  reset_out_a: assert property (@(posedge clk)
    srst |=> (!pll_clock_select && !lock_indication && post_gain == 8'h40))
    else $error("lock outputs reset wrong");

  thr_reset_a: assert property (@(posedge clk)
    srst |=> (fifo_lower_threshold == 8'hFF && phase_err_threshold == 21'h08000))
    else $error("thresholds reset wrong");

  scale_reset_a: assert property (@(posedge clk)
    srst |=> {q_scale, q_offset, q_negate, q_subtract} == 22'h000000)
    else $error("scale or offset reset wrong");
endmodule : calib_loop_lock_regs
`default_nettype wire

// ===== hw/calib_regs_pkg.sv
// Offsets, field positions and reset values of the calibration, loop and lock registers
package calib_regs_pkg;
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] Q_CAL_ADDR = 5'h04;
  localparam logic [ADDR_W-1:0] GAIN_PE_ADDR = 5'h05;
  localparam logic [ADDR_W-1:0] LOOP_FILT_ADDR = 5'h06;
  localparam logic [ADDR_W-1:0] LOCK_DET_ADDR = 5'h07;

  localparam logic [31:0] Q_CAL_RESET = 32'hFF000002;
  localparam logic [31:0] GAIN_PE_RESET = 32'h02FFFFFF;
  localparam logic [31:0] LOOP_FILT_RESET = 32'h50000000;
  localparam logic [31:0] LOCK_DET_RESET = 32'h00040000;
  // Bit that always reads as zero in the loop filter register
  localparam logic [31:0] LOOP_FILT_WMASK = 32'h7FFFFFFF;

  // Q calibration fields
  localparam int Q_THR_LSB = 24;
  localparam int Q_SCALE_LSB = 14;
  localparam int Q_OFFS_LSB = 4;
  localparam int Q_NEG_BIT = 3;
  localparam int Q_SUB_BIT = 2;
  localparam int Q_RND_LSB = 0;
  localparam logic [1:0] Q_RND_RESET = 2'h2;

  // Gain and phase error fields
  localparam int PS_GAIN_LSB = 26;
  localparam int PS_SHIFT_LSB = 22;
  localparam int N_CNT_LSB = 8;
  localparam int M_CNT_LSB = 0;
  localparam logic [1:0] PS_GAIN_INT = 2'h1;
  localparam logic [3:0] PS_SHIFT_RESET = 4'hB;

  // Loop filter fields
  localparam int INV_PHASE_BIT = 30;
  localparam int INV_FREQ_BIT = 29;
  localparam int DIS_OFFS_BIT = 28;
  localparam int LAG_GAIN_LSB = 24;
  localparam int FRQ_GAIN_LSB = 20;
  localparam int LEAD_GAIN_LSB = 16;
  localparam int LAG_SHIFT_LSB = 11;
  localparam int FRQ_SHIFT_LSB = 6;
  localparam int LEAD_SHIFT_LSB = 1;
  localparam int ZERO_ACC_BIT = 0;

  // Lock detect fields
  localparam int USE_ALOCK_BIT = 31;
  localparam int VCO_DIV_LSB = 28;
  localparam int REF_DIV_LSB = 26;
  localparam int PLL_EN_BIT = 25;
  localparam int PLL_CLK_BIT = 24;
  localparam int PE_THR_LSB = 3;
  localparam int INC_SEL_LSB = 1;
  localparam int DEC_SEL_BIT = 0;

  // Lock steps in sixteenths
  localparam logic [3:0] DEC_STEP_HALF = 4'h8;
  localparam logic [3:0] DEC_STEP_QUARTER = 4'h4;
endpackage : calib_regs_pkg

// ===== hw/pin_sync.sv
// Three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/100ps
`default_nettype none
module pin_sync (
  input wire logic clk,
  input wire logic srst,
  input wire logic pin,
  input wire logic reset_level,
  output logic level,
  output logic rise,
  output logic fall
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  always_ff @(posedge clk) begin
    s1_reg <= pin;
    s2_reg <= s1_reg;
    s3_reg <= s2_reg;
  end

  // A change counts only once the second and third stages agree
  always_ff @(posedge clk) begin
    if (srst) begin
      level <= reset_level;
      rise <= 1'b0;
      fall <= 1'b0;
    end else begin
      rise <= (s2_reg == s3_reg) && s3_reg && !level;
      fall <= (s2_reg == s3_reg) && !s3_reg && level;
      if (s2_reg == s3_reg) begin
        level <= s3_reg;
      end
    end
  end
endmodule : pin_sync
`default_nettype wire

// ===== dv/tb_modulator_calib_loop_lock_regs.sv
// Self-checking bench for the calibration, loop filter and lock detect registers
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, o) begin samples_checked++; if ((e) !== (o)) begin n_fail++; \
  $display("wrong value %s expected %0h seen %0h", nm, e, o); end end
module tb_modulator_calib_loop_lock_regs;
  typedef struct {logic [63:0] exp; int sel;} note_t;
  logic clk, srst, cpu_wr_n, analog_lock_pin, digital_lock;
  logic [4:0] cpu_addr;
  logic [31:0] cpu_wdata, cpu_rdata;
  logic [7:0] fifo_lower_threshold, post_gain, ped_m_count;
  logic [9:0] q_scale, q_offset;
  logic [1:0] q_round_mode;
  logic q_negate, q_subtract, invert_phase, invert_freq, disable_offset_freq, zero_accum;
  logic lock_indication, pll_enable, pll_clock_select;
  logic [3:0] post_shift, lag_gain, frq_gain, lead_gain, ref_divisor, lock_inc_step, lock_dec_step;
  logic [13:0] ped_n_count;
  logic [4:0] lag_shift, frq_shift, lead_shift;
  logic [5:0] vco_multiplier;
  logic [20:0] phase_err_threshold;
  logic [31:0] mdl [4];
  logic [63:0] q_seen, gain_seen, loop_seen, lock_seen;
  note_t notes[$];
  note_t n;
  event take;
  int n_fail = 0;
  int samples_checked = 0;

  calib_loop_lock_regs DUT (.clk(clk), .srst(srst), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
    .cpu_wr_n(cpu_wr_n), .cpu_rdata(cpu_rdata), .analog_lock_pin(analog_lock_pin),
    .digital_lock(digital_lock), .fifo_lower_threshold(fifo_lower_threshold), .q_scale(q_scale),
    .q_negate(q_negate), .q_offset(q_offset), .q_subtract(q_subtract), .q_round_mode(q_round_mode),
    .post_gain(post_gain), .post_shift(post_shift), .ped_n_count(ped_n_count),
    .ped_m_count(ped_m_count), .invert_phase(invert_phase), .invert_freq(invert_freq),
    .disable_offset_freq(disable_offset_freq), .lag_gain(lag_gain), .frq_gain(frq_gain),
    .lead_gain(lead_gain), .lag_shift(lag_shift), .frq_shift(frq_shift), .lead_shift(lead_shift),
    .zero_accum(zero_accum), .lock_indication(lock_indication), .vco_multiplier(vco_multiplier),
    .ref_divisor(ref_divisor), .pll_enable(pll_enable), .pll_clock_select(pll_clock_select),
    .phase_err_threshold(phase_err_threshold), .lock_inc_step(lock_inc_step),
    .lock_dec_step(lock_dec_step));

  // Q, gain and loop outputs gathered in register bit order, lock outputs in the order of exp_lock, so each compare stays on one line
  assign q_seen = {32'h0, fifo_lower_threshold, q_scale, q_offset, q_negate, q_subtract, q_round_mode};
  assign gain_seen = {32'h0, post_gain[5:0], post_shift, ped_n_count, ped_m_count};
  assign loop_seen = {33'h0, invert_phase, invert_freq, disable_offset_freq, lag_gain, frq_gain, lead_gain,
    lag_shift, frq_shift, lead_shift, zero_accum};
  assign lock_seen = {21'h0, phase_err_threshold, post_gain[7:6], vco_multiplier, ref_divisor, pll_enable,
    pll_clock_select, lock_inc_step, lock_dec_step};

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Decoded lock outputs expected from a stored lock word; codes above 5 saturate at 32x
  function automatic logic [63:0] exp_lock(input logic [31:0] w);
    logic [5:0] vco;
    vco = (w[30:28] > 3'h5) ? 6'h20 : 6'(1 << w[30:28]);
    return {21'h0, w[23:3], 2'h1, vco, 4'(1 << w[27:26]), w[25], w[24] & w[25],
      4'(1 << w[2:1]), w[0] ? 4'h4 : 4'h8};
  endfunction : exp_lock

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done

  task automatic note(input logic [63:0] e, input int s);
    @(negedge clk);
    notes.push_back('{exp: e, sel: s});
    -> take;
  endtask : note

  task automatic do_reset;
    @(posedge clk);
    srst <= 1'b1;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    mdl[0] = 32'hFF000002;
    mdl[1] = 32'h02FFFFFF;
    mdl[2] = 32'h50000000;
    mdl[3] = 32'h00040000;
  endtask : do_reset

  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    @(posedge clk);
    cpu_addr <= a;
    @(posedge clk);
    note({32'h0, e}, 0);
  endtask : rd

  // Data is set an edge before the strobe falls and held well past the sync delay
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    cpu_addr <= a;
    cpu_wdata <= d;
    @(posedge clk);
    cpu_wr_n <= 1'b0;
    repeat (4) @(posedge clk);
    cpu_wr_n <= 1'b1;
    repeat (5) @(posedge clk);
    if (a >= 5'h04 && a <= 5'h07) mdl[a - 5'h04] = (a == 5'h06) ? (d & 32'h7FFFFFFF) : d;
  endtask : wr

  task automatic check_all;
    for (int i = 0; i < 4; i++) begin
      rd(5'(4 + i), mdl[i]);
      note(i == 3 ? exp_lock(mdl[3]) : {32'h0, mdl[i]}, i + 1);
    end
  endtask : check_all

  always begin
    @(take);
    n = notes.pop_front();
    case (n.sel)
      0: `CHK("cpu_rdata", n.exp, {32'h0, cpu_rdata})
      1: `CHK("q fields", n.exp, q_seen)
      2: `CHK("gain fields", n.exp, gain_seen)
      3: `CHK("loop fields", n.exp, loop_seen)
      4: `CHK("lock fields", n.exp, lock_seen)
      default: `CHK("lock_indication", n.exp, {63'h0, lock_indication})
    endcase
  end

  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    test_done();
  end

  initial begin
    int r;
    logic [4:0] a;
    logic [31:0] d;
    void'($urandom(32'h59C07CD4));
    srst = 1'b1;
    cpu_wr_n = 1'b1;
    cpu_addr = 5'h00;
    cpu_wdata = 32'h0;
    analog_lock_pin = 1'b0;
    digital_lock = 1'b0;
    do_reset();
    check_all();
    rd(5'h08, 32'h0);
    // Random words to every register, plus writes to neighbours outside the bank
    for (int k = 0; k < 40; k++) begin
      r = $urandom_range(0, 5);
      a = (r < 4) ? 5'(4 + r) : ((r == 4) ? 5'h08 : 5'h03);
      d = $urandom();
      if (a == 5'h05 && d[7:0] < 8'h04) d[7:0] = 8'h04;
      wr(a, d);
      check_all();
      rd(a, (a >= 5'h04 && a <= 5'h07) ? mdl[a - 5'h04] : 32'h0);
    end
    // Every divider, increment and decrement code
    for (int i = 0; i < 8; i++) begin
      d = $urandom();
      d[30:28] = 3'(i);
      d[27:26] = 2'(i);
      d[2:1] = 2'(i >> 1);
      d[0] = i[0];
      wr(5'h07, d);
      note(exp_lock(mdl[3]), 4);
    end
    // Lock source selection; analog pin passes a synchroniser so allow settling
    wr(5'h07, 32'h80040000);
    @(posedge clk);
    analog_lock_pin <= 1'b1;
    repeat (8) @(posedge clk);
    note(64'h1, 5);
    analog_lock_pin <= 1'b0;
    digital_lock <= 1'b1;
    repeat (8) @(posedge clk);
    note(64'h0, 5);
    wr(5'h07, 32'h00040000);
    repeat (4) @(posedge clk);
    note(64'h1, 5);
    do_reset();
    check_all();
    repeat (2) @(posedge clk);
    test_done();
  end
endmodule : tb_modulator_calib_loop_lock_regs
`default_nettype wire
